// ---- verilog/framer_pkg.sv ----
// How it works
// - Host link is a full-duplex UART at one megabit per second.
// - Each side pauses sending while its peer's handshake line says not ready.
// - Byte values 0x7F start, 0x7D escape and 0xFF end are reserved.
// - A message is start byte, payload bytes, one end byte, nothing interleaved.
// - Reserved payload bytes go out as escape plus byte with bit 5 cleared.
// - A start byte anywhere aborts the partial frame (an END_ABORT entry if its service code was queued) and restarts the receiver.
// - A stray 0xFF outside a frame is taken as a long stop and ignored.
// - Multi-byte fields, the service code among them, travel low byte first.
// - After the start byte: two-byte service code, any payload, then the end byte.
// - The start byte value is a parameter because 0x7E is also quoted.
// - Service code bits 15..14: 00 request, 01 indicate, 10 confirm, 11 unused.
// - Service code bits 13..0 carry the service ID 0x41 to 0x47.
// - At most one outstanding request per service ID; wait for its confirm.
// - Indicate messages are never confirmed and change no request tracking.
// - A confirm clears the outstanding request with the same service ID.
// - The module drops its clear-to-send output low for about 2 us to wake the host.
package framer_pkg;
   localparam int CLK_NS  = 10;
   localparam int BIT_NS  = 1000;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam int CNT_W   = 7;
   localparam logic [CNT_W-1:0] BIT_LOAD  = CNT_W'(BIT_CYC - 1);
   localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(BIT_CYC / 2 - 1);
   localparam int WAKE_NS  = 2000;
   localparam int WAKE_W   = 8;
   localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_NS / CLK_NS);

   localparam logic [7:0] SOF_DEFAULT = 8'h7F;
   localparam logic [7:0] ESC_BYTE    = 8'h7D;
   localparam logic [7:0] EOF_BYTE    = 8'hFF;
   localparam logic [7:0] ESC_MASK    = 8'h20;

   localparam logic [1:0] TYPE_REQ    = 2'h0;
   localparam logic [1:0] TYPE_IND    = 2'h1;
   localparam logic [1:0] TYPE_CNF    = 2'h2;
   localparam logic [1:0] TYPE_UNUSED = 2'h3;
   localparam logic [7:0] SID_FIRST   = 8'h41;
   localparam logic [7:0] SID_LAST    = 8'h47;
   localparam int SID_NUM = 7;

   localparam int FIFO_W     = 10;
   localparam int FIFO_D     = 32;
   localparam int LVL_W      = 6;
   localparam logic [LVL_W-1:0] CTS_FILL = 6'h18;
   localparam logic [7:0] END_OK    = 8'h00;
   localparam logic [7:0] END_ABORT = 8'h01;

   typedef enum logic [1:0] {K_DATA, K_SVC_LO, K_SVC_HI, K_END} kind_t;
   typedef enum logic [2:0] {T_WAIT, T_SOF, T_ESC, T_DATA, T_EOF, T_HOLD} tx_state_t;

   function automatic logic is_rsv(input logic [7:0] b, input logic [7:0] sof);
      return (b == sof) || (b == ESC_BYTE) || (b == EOF_BYTE);
   endfunction

   function automatic logic sid_ok(input logic [5:0] hi, input logic [7:0] lo);
      return (hi == 6'h00) && (lo >= SID_FIRST) && (lo <= SID_LAST);
   endfunction

   function automatic logic [2:0] sid_idx(input logic [7:0] lo);
      return 3'(lo - SID_FIRST);
   endfunction
endpackage

// ---- verilog/fifo_if.sv ----
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 10, parameter int LW = 6);
   logic          push_valid;
   logic          push_ready;
   logic [W-1:0]  push_data;
   logic          pop_valid;
   logic          pop_ready;
   logic [W-1:0]  pop_data;
   logic [LW-1:0] level;
   modport fill  (output push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data, level);
   modport store (input  push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, level);
endinterface

// ---- verilog/msg_fifo.sv ----
`timescale 1ns/1ns
module msg_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rst,
   fifo_if.store    f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign push         = f.push_valid && f.push_ready;
   assign pop          = f.pop_valid && f.pop_ready;
   assign f.push_ready = cnt_ff != FULL_CNT;
   assign f.pop_valid  = cnt_ff != '0;
   assign f.pop_data   = mem[rp_ff];
   assign f.level      = cnt_ff;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_ff] <= f.push_data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_count: assert property (@(posedge mclk) disable iff (rst)
      push && !pop |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("fifo count did not follow a lone push");
   a_fifo_full_hold: assert property (@(posedge mclk) disable iff (rst)
      (cnt_ff == FULL_CNT) && !pop |=> wp_ff == $past(wp_ff))
      else $error("fifo wrote while full");
endmodule

// ---- verilog/radio_framer.sv ----
`timescale 1ns/1ns
module radio_framer import framer_pkg::*; #(
   parameter logic [7:0] START_BYTE = SOF_DEFAULT
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       host_txd,
   input  wire logic       host_wake_request,
   output logic            module_rxd,
   output logic            module_wake_notice,
   input  wire logic       wake_host,
   output logic            radio_wake,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic            rx_valid,
   output logic [1:0]      rx_kind,
   output logic [7:0]      rx_data,
   input  wire logic       rx_ready,
   output logic [6:0]      pending_req,
   output logic            stray_confirm,
   output logic            rx_dropped
);
   localparam int A_BIT_M1 = BIT_CYC - 1;

   fifo_if #(.W(FIFO_W), .LW(LVL_W)) rxq ();

   msg_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .f    (rxq)
   );

   // Pin synchronisers; the third handshake flop only feeds the edge detector.
   logic rxd_s1_ff, rxd_s2_ff, rts_s1_ff, rts_s2_ff, rts_s3_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxd_s1_ff <= 1'b1;
         rxd_s2_ff <= 1'b1;
         rts_s1_ff <= 1'b0;
         rts_s2_ff <= 1'b0;
         rts_s3_ff <= 1'b0;
      end else begin
         rxd_s1_ff <= host_txd;
         rxd_s2_ff <= rxd_s1_ff;
         rts_s1_ff <= host_wake_request;
         rts_s2_ff <= rts_s1_ff;
         rts_s3_ff <= rts_s2_ff;
      end
   end

   // Any edge on the handshake line is a wake request for the radio side.
   // The detector arms only once the synchroniser holds the pin's real level,
   // so the reset value of the chain never shows up as a false wake.
   logic [1:0] rts_arm_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rts_arm_ff <= 2'h0;
         radio_wake <= 1'b0;
      end else begin
         if (rts_arm_ff != 2'h3) begin
            rts_arm_ff <= rts_arm_ff + 1'b1;
         end
         radio_wake <= (rts_arm_ff == 2'h3) && (rts_s2_ff ^ rts_s3_ff);
      end
   end

   // Clear-to-send: high while the queue level is below CTS_FILL, dropped briefly to wake the host.
   logic [WAKE_W-1:0] wake_cnt_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wake_cnt_ff        <= '0;
         module_wake_notice <= 1'b0;
      end else begin
         if (wake_host) begin
            wake_cnt_ff <= WAKE_LOAD;
         end else if (wake_cnt_ff != '0) begin
            wake_cnt_ff <= wake_cnt_ff - 1'b1;
         end
         module_wake_notice <= (wake_cnt_ff == '0) && !wake_host
                               && (rxq.level < CTS_FILL);
      end
   end

   // Transmit serializer, 8N1 with the bit clock from a reloading divider.
   logic             ser_go;
   logic [7:0]       ser_char;
   logic [8:0]       ser_sh_ff;
   logic [3:0]       ser_left_ff;
   logic [CNT_W-1:0] tx_div_ff;
   logic             ser_busy;
   logic             tx_tick;
   logic             chr0_ff;
   assign ser_busy = ser_left_ff != 4'h0;
   assign tx_tick  = ser_busy && (tx_div_ff == '0);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ser_sh_ff   <= '1;
         ser_left_ff <= 4'h0;
         tx_div_ff   <= '0;
         module_rxd  <= 1'b1;
         chr0_ff     <= 1'b1;
      end else if (ser_go) begin
         ser_sh_ff   <= {1'b1, ser_char};
         ser_left_ff <= 4'hA;
         tx_div_ff   <= BIT_LOAD;
         module_rxd  <= 1'b0;
         chr0_ff     <= ser_char[0];
      end else if (ser_busy) begin
         tx_div_ff <= (tx_div_ff == '0) ? BIT_LOAD : tx_div_ff - 1'b1;
         if (tx_tick) begin
            ser_left_ff <= ser_left_ff - 1'b1;
            module_rxd  <= (ser_left_ff > 4'h1) ? ser_sh_ff[0] : 1'b1;
            ser_sh_ff   <= {1'b1, ser_sh_ff[8:1]};
         end
      end
   end

   // Transmit framer: first byte taken is the service code low byte, then high.
   tx_state_t  tx_state_ff;
   logic [7:0] cur_ff;
   logic [7:0] tx_lo_ff;
   logic [1:0] tx_cnt_ff;
   logic       last_ff, esc_sent_ff, in_msg_ff;
   logic       take, blk, cur_rsv, tx_set;
   logic [6:0] pend_ff;

   assign take    = tx_valid && tx_ready;
   assign blk     = (tx_cnt_ff == 2'h1) && (tx_data[7:6] == TYPE_REQ)
                    && sid_ok(tx_data[5:0], tx_lo_ff) && pend_ff[sid_idx(tx_lo_ff)];
   assign cur_rsv = is_rsv(cur_ff, START_BYTE);
   assign ser_go  = rts_s2_ff && !ser_busy
                    && (tx_state_ff inside {T_SOF, T_ESC, T_DATA, T_EOF});
   assign tx_set  = ser_go && (tx_state_ff == T_DATA) && (tx_cnt_ff == 2'h1)
                    && (cur_ff[7:6] == TYPE_REQ) && sid_ok(cur_ff[5:0], tx_lo_ff);

   always_comb begin
      unique case (tx_state_ff)
         T_SOF:   ser_char = START_BYTE;
         T_ESC:   ser_char = ESC_BYTE;
         T_DATA:  ser_char = esc_sent_ff ? (cur_ff & ~ESC_MASK) : cur_ff;
         T_EOF:   ser_char = EOF_BYTE;
         default: ser_char = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_state_ff <= T_WAIT;
         tx_ready    <= 1'b1;
         cur_ff      <= 8'h00;
         tx_lo_ff    <= 8'h00;
         tx_cnt_ff   <= 2'h0;
         last_ff     <= 1'b0;
         esc_sent_ff <= 1'b0;
         in_msg_ff   <= 1'b0;
      end else begin
         unique case (tx_state_ff)
            T_WAIT: if (take) begin
               cur_ff      <= tx_data;
               last_ff     <= tx_last;
               esc_sent_ff <= 1'b0;
               tx_ready    <= 1'b0;
               if (!in_msg_ff) begin
                  tx_state_ff <= T_SOF;
               end else if (blk) begin
                  tx_state_ff <= T_HOLD;
               end else begin
                  tx_state_ff <= is_rsv(tx_data, START_BYTE) ? T_ESC : T_DATA;
               end
            end
            T_SOF: if (ser_go) begin
               in_msg_ff   <= 1'b1;
               tx_state_ff <= cur_rsv ? T_ESC : T_DATA;
            end
            T_HOLD: if (!pend_ff[sid_idx(tx_lo_ff)]) begin
               tx_state_ff <= cur_rsv ? T_ESC : T_DATA;
            end
            T_ESC: if (ser_go) begin
               esc_sent_ff <= 1'b1;
               tx_state_ff <= T_DATA;
            end
            T_DATA: if (ser_go) begin
               if (tx_cnt_ff == 2'h0) begin
                  tx_lo_ff <= cur_ff;
               end
               if (tx_cnt_ff != 2'h2) begin
                  tx_cnt_ff <= tx_cnt_ff + 1'b1;
               end
               tx_state_ff <= last_ff ? T_EOF : T_WAIT;
               tx_ready    <= !last_ff;
            end
            T_EOF: if (ser_go) begin
               in_msg_ff   <= 1'b0;
               tx_cnt_ff   <= 2'h0;
               tx_state_ff <= T_WAIT;
               tx_ready    <= 1'b1;
            end
         endcase
      end
   end

   // Receive UART: start bit checked at mid-bit, then one sample per bit time.
   logic [CNT_W-1:0] rx_div_ff;
   logic [3:0]       rx_bit_ff;
   logic [7:0]       rx_sh_ff;
   logic             rx_on_ff, char_ev_ff, ferr_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_div_ff  <= '0;
         rx_bit_ff  <= 4'h0;
         rx_sh_ff   <= 8'h00;
         rx_on_ff   <= 1'b0;
         char_ev_ff <= 1'b0;
         ferr_ff    <= 1'b0;
      end else begin
         char_ev_ff <= 1'b0;
         ferr_ff    <= 1'b0;
         if (!rx_on_ff) begin
            if (!rxd_s2_ff) begin
               rx_on_ff  <= 1'b1;
               rx_div_ff <= HALF_LOAD;
               rx_bit_ff <= 4'h0;
            end
         end else if (rx_div_ff != '0) begin
            rx_div_ff <= rx_div_ff - 1'b1;
         end else begin
            rx_div_ff <= BIT_LOAD;
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == 4'h0) begin
               rx_on_ff <= !rxd_s2_ff;
            end else if (rx_bit_ff != 4'h9) begin
               rx_sh_ff <= {rxd_s2_ff, rx_sh_ff[7:1]};
            end else begin
               rx_on_ff   <= 1'b0;
               char_ev_ff <= rxd_s2_ff;
               ferr_ff    <= !rxd_s2_ff;
            end
         end
      end
   end

   // Receive deframer.
   logic       in_frame_ff, rx_esc_ff, drop_ff, pv_ff, pend_hi_ff;
   logic [1:0] rcnt_ff;
   logic [7:0] rx_lo_ff, rx_hi_ff;
   logic [9:0] pd_ff;
   logic       is_sof, is_eof, is_esc, data_ev, hi_ev, need_push;
   logic [7:0] rx_b;
   logic [9:0] nd;
   assign is_sof  = char_ev_ff && (rx_sh_ff == START_BYTE);
   assign is_eof  = char_ev_ff && (rx_sh_ff == EOF_BYTE);
   assign is_esc  = char_ev_ff && (rx_sh_ff == ESC_BYTE);
   assign data_ev = char_ev_ff && in_frame_ff && !is_sof && !is_eof && !is_esc;
   assign rx_b    = rx_esc_ff ? (rx_sh_ff | ESC_MASK) : rx_sh_ff;
   assign hi_ev   = data_ev && (rcnt_ff == 2'h1);

   always_comb begin
      need_push = 1'b0;
      nd        = {K_DATA, rx_b};
      if (hi_ev && (rx_b[7:6] != TYPE_UNUSED)) begin
         need_push = 1'b1;
         nd        = {K_SVC_LO, rx_lo_ff};
      end else if (data_ev && (rcnt_ff == 2'h2) && !drop_ff) begin
         need_push = 1'b1;
      end else if ((is_eof || is_sof) && in_frame_ff && (rcnt_ff == 2'h2) && !drop_ff) begin
         need_push = 1'b1;
         nd        = {K_END, is_eof ? END_OK : END_ABORT};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_frame_ff <= 1'b0;
         rx_esc_ff   <= 1'b0;
         drop_ff     <= 1'b0;
         rcnt_ff     <= 2'h0;
         rx_lo_ff    <= 8'h00;
         rx_hi_ff    <= 8'h00;
      end else if (is_sof) begin
         in_frame_ff <= 1'b1;
         rx_esc_ff   <= 1'b0;
         drop_ff     <= 1'b0;
         rcnt_ff     <= 2'h0;
      end else if (char_ev_ff && in_frame_ff) begin
         if (is_eof) begin
            in_frame_ff <= 1'b0;
         end else if (is_esc) begin
            rx_esc_ff <= 1'b1;
         end else begin
            rx_esc_ff <= 1'b0;
            if (rcnt_ff == 2'h0) begin
               rx_lo_ff <= rx_b;
            end else if (rcnt_ff == 2'h1) begin
               rx_hi_ff <= rx_b;
               drop_ff  <= rx_b[7:6] == TYPE_UNUSED;
            end
            if (rcnt_ff != 2'h2) begin
               rcnt_ff <= rcnt_ff + 1'b1;
            end
         end
      end
   end

   // Push staging; a second push carries the service code high byte.
   assign rxq.push_valid = pv_ff;
   assign rxq.push_data  = pd_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pv_ff      <= 1'b0;
         pd_ff      <= '0;
         pend_hi_ff <= 1'b0;
         rx_dropped <= 1'b0;
      end else begin
         rx_dropped <= ferr_ff;
         if (need_push) begin
            if (pv_ff && !rxq.push_ready) begin
               rx_dropped <= 1'b1;
            end else begin
               pv_ff      <= 1'b1;
               pd_ff      <= nd;
               pend_hi_ff <= hi_ev;
            end
         end else if (pv_ff && rxq.push_ready) begin
            pv_ff      <= pend_hi_ff;
            pd_ff      <= {K_SVC_HI, rx_hi_ff};
            pend_hi_ff <= 1'b0;
         end
      end
   end

   // Outstanding request tracking, one bit per service ID.
   logic rx_cnf;
   assign rx_cnf = hi_ev && (rx_b[7:6] == TYPE_CNF)
                   && sid_ok(rx_b[5:0], rx_lo_ff);
   assign pending_req = pend_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_ff       <= '0;
         stray_confirm <= 1'b0;
      end else begin
         stray_confirm <= rx_cnf && !pend_ff[sid_idx(rx_lo_ff)];
         if (rx_cnf) begin
            pend_ff[sid_idx(rx_lo_ff)] <= 1'b0;
         end
         if (tx_set) begin
            pend_ff[sid_idx(tx_lo_ff)] <= 1'b1;
         end
      end
   end

   // Registered output stage of the receive queue.
   assign rxq.pop_ready = !rx_valid || rx_ready;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_valid <= 1'b0;
         rx_kind  <= 2'h0;
         rx_data  <= 8'h00;
      end else if (rxq.pop_ready) begin
         rx_valid <= rxq.pop_valid;
         rx_kind  <= rxq.pop_data[9:8];
         rx_data  <= rxq.pop_data[7:0];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   a_char_bit_time: assert property (
      ser_go |=> !module_rxd ##A_BIT_M1 !module_rxd ##1 (module_rxd == chr0_ff))
      else $error("start bit length or first data bit wrong");
   a_cts_pause: assert property (!rts_s2_ff && !ser_busy |=> !ser_busy)
      else $error("character started while host not ready");
   a_frame_start: assert property (
      ser_go && (tx_state_ff == T_SOF) |-> ser_char == START_BYTE ##1 in_msg_ff)
      else $error("frame did not open with the start byte");
   a_escape_mask: assert property (
      ser_go && (tx_state_ff == T_ESC) |=> esc_sent_ff && (tx_state_ff == T_DATA)
      && !ser_char[5])
      else $error("escaped byte not sent with bit 5 clear");
   a_rx_restart: assert property (is_sof |=> in_frame_ff && (rcnt_ff == 2'h0))
      else $error("start byte did not restart receiver");
   a_stray_end: assert property (
      is_eof && !in_frame_ff |=> !in_frame_ff && $stable(rcnt_ff) && !$rose(pv_ff))
      else $error("stray end byte disturbed receiver");
   a_unused_drop: assert property (
      hi_ev && (rx_b[7:6] == TYPE_UNUSED) |=> drop_ff && !$rose(pv_ff)
      && $stable(pend_ff) && !stray_confirm)
      else $error("unused service type not discarded");
   a_request_block: assert property (tx_set |-> !pend_ff[sid_idx(tx_lo_ff)])
      else $error("second outstanding request for one service ID");
   a_confirm_clear: assert property (
      rx_cnf && !tx_set |=> !pend_ff[sid_idx(rx_lo_ff)])
      else $error("confirm did not clear its request");
   a_indicate_quiet: assert property (
      hi_ev && (rx_b[7:6] == TYPE_IND) && !tx_set |=> $stable(pend_ff) && !stray_confirm)
      else $error("indicate changed request tracking");
   a_wake_toggle: assert property (wake_host |=> !module_wake_notice [*8])
      else $error("wake request did not drop clear-to-send");

   c_escape_sent: cover property (ser_go && (tx_state_ff == T_ESC));
   c_confirm_match: cover property (rx_cnf && pend_ff[sid_idx(rx_lo_ff)]);
   c_frame_abort: cover property (need_push && (nd[9:8] == K_END) && is_sof);
   c_queue_full: cover property (pv_ff && !rxq.push_ready);
endmodule

// ---- tb/host_uart_model.sv ----
`timescale 1ns/1ns
module host_uart_model (
   input  wire logic mclk,
   input  wire logic module_rxd,
   input  wire logic module_wake_notice,
   output logic      host_txd,
   output logic      host_wake_request
);
   logic [7:0] got[$];
   logic [7:0] rb;
   initial begin
      host_txd = 1'b1;
      host_wake_request = 1'b1;
   end
   // One 8N1 character, held back while the module reports no room.
   task automatic send(input logic [7:0] b);
      @(posedge mclk);
      while (module_wake_notice !== 1'b1) @(posedge mclk);
      for (int i = -1; i < 9; i++) begin
         host_txd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i[2:0]];
         repeat (100) @(posedge mclk);
      end
   endtask
   task automatic toggle_wake();
      host_wake_request <= ~host_wake_request;
   endtask
   // Samples each character at bit centres; a low stop bit spoils the byte.
   initial forever begin
      @(posedge mclk);
      if (module_rxd === 1'b0) begin
         repeat (50) @(posedge mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (100) @(posedge mclk);
            rb[i] = module_rxd;
         end
         repeat (100) @(posedge mclk);
         got.push_back((module_rxd === 1'b1) ? rb : 8'hXX);
      end
   end
endmodule

// ---- tb/radio_modem_serial_framer_tb.sv ----
`timescale 1ns/1ns
module radio_modem_serial_framer_tb;
   logic       mclk, rst, host_txd, host_wake_request, module_rxd, module_wake_notice;
   logic       wake_host, radio_wake, tx_valid, tx_last, tx_ready, rx_valid, rx_ready;
   logic       stray_confirm, rx_dropped;
   logic [7:0] tx_data, rx_data;
   logic [1:0] rx_kind;
   logic [6:0] pending_req;
   logic [9:0] rxq[$];
   int         miscompares, tests_run, wakes, strays, drops;

   radio_framer uut (.mclk(mclk), .rst(rst), .host_txd(host_txd),
      .host_wake_request(host_wake_request), .module_rxd(module_rxd),
      .module_wake_notice(module_wake_notice), .wake_host(wake_host),
      .radio_wake(radio_wake), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_data(rx_data),
      .rx_ready(rx_ready), .pending_req(pending_req), .stray_confirm(stray_confirm),
      .rx_dropped(rx_dropped));
   host_uart_model host (.mclk(mclk), .module_rxd(module_rxd),
      .module_wake_notice(module_wake_notice), .host_txd(host_txd),
      .host_wake_request(host_wake_request));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back({rx_kind, rx_data});
      if (radio_wake === 1'b1) wakes++;
      if (stray_confirm === 1'b1) strays++;
      if (rx_dropped === 1'b1) drops++;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Offers bytes while keeping valid high between takes.
   task automatic send_msg(input logic [7:0] m[$]);
      @(posedge mclk);
      foreach (m[i]) begin
         tx_valid <= 1'b1;
         tx_data <= m[i];
         tx_last <= (i == m.size() - 1);
         @(posedge mclk);
         while (tx_ready !== 1'b1) @(posedge mclk);
      end
      tx_valid <= 1'b0;
   endtask
   task automatic host_rx(input logic [7:0] m[$], input logic [9:0] e[$]);
      int n = 0;
      foreach (m[i]) host.send(m[i]);
      while (rxq.size() < e.size() && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk("rx count", e.size(), rxq.size());
      foreach (e[i]) if (i < rxq.size()) chk("rx entry", e[i], rxq[i]);
      rxq.delete();
   endtask

   task automatic test_tx_stuffing();
      logic [7:0] exp[$];
      int n = 0;
      exp = '{8'h7F, 8'h41, 8'h00, 8'h7D, 8'h5D, 8'h7D, 8'hDF, 8'hFF};
      send_msg('{8'h41, 8'h00, 8'h7D, 8'hFF});
      while (host.got.size() < 8 && n < 12000) begin
         @(posedge mclk);
         n++;
      end
      chk("host count", 8, host.got.size());
      foreach (exp[i]) chk("host byte", exp[i], host.got[i]);
      chk("pending", 7'h01, pending_req);
      $display("test tx_stuffing done");
   endtask
   // A second request for a pending ID is held until its confirm arrives.
   task automatic test_rx_confirm();
      host.got.delete();
      send_msg('{8'h41, 8'h00});
      repeat (1500) @(posedge mclk);
      chk("held count", 2, host.got.size());
      host_rx('{8'hFF, 8'h7F, 8'h41, 8'h80, 8'h7D, 8'h5F, 8'hFF,
                8'h7F, 8'h43, 8'h80, 8'hFF},
              '{10'h141, 10'h280, 10'h07F, 10'h300,
                10'h143, 10'h280, 10'h300});
      chk("held bytes", 16'h00FF, {host.got[2], host.got[3]});
      chk("stray confirms", 1, strays);
      chk("pending", 7'h01, pending_req);
      $display("test rx_confirm done");
   endtask
   task automatic test_rx_restart();
      host_rx('{8'h7F, 8'h42, 8'h40, 8'h11, 8'h7F, 8'h43, 8'hC0, 8'h22, 8'hFF,
                8'h7F, 8'h41, 8'h80, 8'hFF},
              '{10'h142, 10'h240, 10'h011, 10'h301, 10'h141, 10'h280, 10'h300});
      chk("pending", 7'h00, pending_req);
      chk("stray confirms", 1, strays);
      chk("dropped", 0, drops);
      $display("test rx_restart done");
   endtask
   task automatic test_wake();
      int n = 0;
      @(posedge mclk);
      wake_host <= 1'b1;
      @(posedge mclk);
      wake_host <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (module_wake_notice !== 1'b1 && n < 400);
      chk("notice low span", 1, n >= 199 && n <= 202);
      chk("wake pulses", 0, wakes);
      wakes = 0;
      host.toggle_wake();
      repeat (10) @(posedge mclk);
      chk("wake pulses", 1, wakes);
      host.toggle_wake();
      repeat (10) @(posedge mclk);
      chk("wake pulses", 2, wakes);
      $display("test wake done");
   endtask

   initial begin
      rst = 1'b1;
      wake_host = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      tx_last = 1'b0;
      rx_ready = 1'b0;
      miscompares = 0;
      tests_run = 0;
      wakes = 0;
      strays = 0;
      drops = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rx_ready <= 1'b1;
      repeat (4) @(posedge mclk);
      test_tx_stuffing();
      test_rx_confirm();
      test_rx_restart();
      test_wake();
      finish_test();
   end
   initial begin
      #800000;
      miscompares++;
      $display("mismatch watchdog expected done seen timeout");
      finish_test();
   end
endmodule
